// file: pkg/sbcpc_pkg.sv
// Package: constants, states and carrier structs of the pin control block
package sbcpc_pkg;

  // Register port addresses (word index on the plain port)
  localparam logic [3:0] ADDR_MODE_CTRL = 4'h0;
  localparam logic [3:0] ADDR_INT_EN    = 4'h1;
  localparam logic [3:0] ADDR_IO_STATUS = 4'h2;
  localparam logic [3:0] ADDR_INT_STAT  = 4'h3;
  localparam logic [3:0] ADDR_WAKE_EN   = 4'h4;

  // Field positions of mode_control_reg
  localparam int MCR_MODE_LSB  = 0;   // Mode request, 2 bits
  localparam int MCR_BATTERY_FAIL_FLAG   = 4;   // Battery fail, write 1 to clear
  localparam int MCR_TEMPWARN  = 5;   // Regulator temperature warning
  localparam int MCR_TSHUT     = 6;   // Regulator shut down
  localparam int MCR_RESET     = 7;   // Device in reset mode

  // Field positions of interrupt enable / status
  localparam int INT_TEMP  = 0;
  localparam int INT_EARLY = 1;
  localparam int INT_WAKE  = 2;

  // Field positions of io_status_reg
  localparam int IOR_LEVEL_LSB = 0;   // Four level inputs
  localparam int IOR_SUP_UV    = 4;   // Battery supply undervoltage
  localparam int IOR_WD_FAULT  = 5;

  // Reset values
  localparam logic [7:0] INT_EN_RST  = 8'h00;
  localparam logic [3:0] WAKE_EN_RST = 4'h0;
  // Synchroniser reset holds select and transmit at their idle high level
  localparam logic [16:0] SYNC_IDLE_RST = 17'h1_4000;
  localparam logic [2:0]  SPI_LAST_BIT  = 3'h7;   // Eighth bit of a frame

  // Timing at 250 MHz (period 4 ns)
  localparam int CLK_PERIOD_NS  = 4;
  localparam int WAKE_PULSE_US  = 10;
  localparam int WAKE_PULSE_CYC = WAKE_PULSE_US * 1000 / CLK_PERIOD_NS;
  localparam int RST_DUR_MS     = 15;
  localparam int RST_DUR_CYC    = RST_DUR_MS * 1000000 / CLK_PERIOD_NS;

  // Operating modes, one-hot
  typedef enum logic [4:0] {
    SBCPC_RESET  = 5'h01,
    SBCPC_NORMAL = 5'h02,
    SBCPC_STBY   = 5'h04,
    SBCPC_STOP   = 5'h08,
    SBCPC_SLEEP  = 5'h10
  } sbcpc_mode_t;

  // Analog comparator results, all asynchronous
  typedef struct packed {
    logic vdd_uv;       // Main regulator below reset threshold
    logic temp_warn;    // Above pre-warning temperature
    logic temp_shut;    // Above shutdown temperature
    logic temp_cool;    // Below restart temperature (hysteresis)
    logic sup_fail;     // Battery supply below fail level
    logic sup_early;    // Battery supply below early-warning level
  } sbcpc_ana_t;

endpackage : sbcpc_pkg

// file: src/sbcpc_top.sv
// Pin control and status logic of the system basis chip
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps

module sbcpc_top #(
  parameter int RST_CYC  = sbcpc_pkg::RST_DUR_CYC,
  parameter int WAKE_CYC = sbcpc_pkg::WAKE_PULSE_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 txd_i,
  input  wire logic                 bus_dom_i,
  input  wire logic [3:0]           level_inputs_i,
  input  wire logic                 spi_cs_n_i,
  input  wire logic                 spi_sclk_i,
  input  wire logic                 spi_mosi_i,
  input  wire logic                 wd_timeout_i,
  input  wire logic                 wd_early_trig_i,
  input  wire sbcpc_pkg::sbcpc_ana_t ana_i,
  input  wire logic [3:0]           reg_addr_i,
  input  wire logic [7:0]           reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic [7:0]                reg_rdata_o,
  output logic                      bus_drive_dom_o,
  output logic                      rxd_o,
  output logic                      rst_n_o,
  output logic                      int_n_o,
  output logic                      watchdog_fault_n_o,
  output logic                      regulator_on_o,
  output logic                      spi_sel_o,
  output logic                      spi_miso_o
);

  localparam int SYNC_W = 6 + 4 + 7;

  // Two-stage synchronisers for every foreign input
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [3:0]        level_prev_r;

  // Mode, flags and registers
  sbcpc_pkg::sbcpc_mode_t mode_r;
  logic [1:0]  mode_req_r;
  logic [31:0] rst_cnt_r;
  logic [31:0] pulse_cnt_r;
  logic        battery_fail_flag_r;
  logic        temp_warn_r;
  logic        shut_r;
  logic        wd_fault_r;
  logic [7:0]  int_en_r;
  logic [7:0]  int_stat_r;
  logic [3:0]  wake_en_r;

  // Synchronised views
  logic       s_txd;
  logic       s_bus;
  logic       s_cs_n;
  logic       s_wd_to;
  logic       s_wd_early;
  logic [3:0] s_level;
  logic       s_vdd_uv;
  logic       s_twarn;
  logic       s_tshut;
  logic       s_tcool;
  logic       s_sfail;
  logic       s_searly;
  logic       s_sclk;
  logic       s_mosi;

  // Serial port state
  logic       sclk_prev_r;
  logic       cs_n_prev_r;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_fall;
  logic [2:0] spi_bit_r;
  logic [7:0] spi_rx_r;
  logic [7:0] spi_rx_nxt;
  logic [7:0] spi_last_r;
  logic [7:0] spi_tx_r;

  logic       wr_mcr;
  logic       wr_ist;
  logic       wake_ev;
  logic       early_act;
  logic [7:0] int_set;
  logic [7:0] rdata_nxt;

  // Decode a write strobe for one address
  function automatic logic wr_hit(input logic [3:0] a,
                                  input logic [3:0] want,
                                  input logic       wr);
    wr_hit = wr && (a == want);
  endfunction : wr_hit

  // Both stages reset to constants; only stage two feeds logic
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      // Idle levels, so no false dominant or select follows reset
      sync1_r <= sbcpc_pkg::SYNC_IDLE_RST;
      sync2_r <= sbcpc_pkg::SYNC_IDLE_RST;
    end else begin
      sync1_r <= {txd_i, bus_dom_i, spi_cs_n_i, spi_sclk_i, spi_mosi_i,
                  wd_timeout_i, wd_early_trig_i, level_inputs_i,
                  ana_i};
      sync2_r <= sync1_r;
    end
  end

  assign {s_txd, s_bus, s_cs_n, s_sclk, s_mosi, s_wd_to, s_wd_early,
          s_level, s_vdd_uv, s_twarn, s_tshut, s_tcool, s_sfail,
          s_searly} = sync2_r;

  assign wr_mcr = wr_hit(reg_addr_i, sbcpc_pkg::ADDR_MODE_CTRL, reg_wr_i);
  assign wr_ist = wr_hit(reg_addr_i, sbcpc_pkg::ADDR_INT_STAT, reg_wr_i);

  // Enabled level change, only meaningful in low-power modes
  assign wake_ev = |((s_level ^ level_prev_r) & wake_en_r) &&
                   (mode_r == sbcpc_pkg::SBCPC_SLEEP ||
                    mode_r == sbcpc_pkg::SBCPC_STOP);
  assign early_act = (mode_r == sbcpc_pkg::SBCPC_NORMAL ||
                      mode_r == sbcpc_pkg::SBCPC_STBY);

  // Hardware sources of interrupt status
  always_comb begin
    int_set = 8'h00;
    int_set[sbcpc_pkg::INT_TEMP]  = s_twarn;
    int_set[sbcpc_pkg::INT_EARLY] = s_searly && early_act;
    int_set[sbcpc_pkg::INT_WAKE]  = wake_ev;
  end

  // Level history for change detection
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      level_prev_r <= 4'h0;
    end else begin
      level_prev_r <= s_level;
    end
  end

  // Serial clock and select history; idle levels avoid a false edge
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sclk_prev_r <= 1'b0;
      cs_n_prev_r <= 1'b1;
    end else begin
      sclk_prev_r <= s_sclk;
      cs_n_prev_r <= s_cs_n;
    end
  end

  // Serial clock edges count only while the port is selected
  assign sclk_rise  = s_sclk && !sclk_prev_r && !s_cs_n;
  assign sclk_fall  = !s_sclk && sclk_prev_r && !s_cs_n;
  assign cs_fall    = !s_cs_n && cs_n_prev_r;
  assign spi_rx_nxt = {spi_rx_r[6:0], s_mosi};

  // Receive shifter samples on the falling edge; a cut frame is dropped
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      spi_rx_r   <= 8'h00;
      spi_last_r <= 8'h00;
      spi_bit_r  <= 3'h0;
    end else if (cs_fall) begin
      spi_bit_r <= 3'h0;
    end else if (sclk_fall) begin
      spi_rx_r  <= spi_rx_nxt;
      spi_bit_r <= spi_bit_r + 3'h1;
      if (spi_bit_r == sbcpc_pkg::SPI_LAST_BIT) begin
        spi_last_r <= spi_rx_nxt;
      end
    end
  end

  // Transmit shifter echoes the last whole byte, updated on rising edge
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      spi_tx_r   <= 8'h00;
      spi_miso_o <= 1'b0;
    end else if (cs_fall) begin
      spi_tx_r <= spi_last_r;
    end else if (sclk_rise) begin
      spi_miso_o <= spi_tx_r[7];
      spi_tx_r   <= {spi_tx_r[6:0], 1'b0};
    end
  end

  // Mode machine; undervoltage and watchdog faults enter reset
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mode_r    <= sbcpc_pkg::SBCPC_RESET;
      rst_cnt_r <= 32'h0000_0000;
    end else if (s_vdd_uv || s_wd_to || s_wd_early) begin
      mode_r    <= sbcpc_pkg::SBCPC_RESET;
      rst_cnt_r <= 32'h0000_0000;
    end else begin
      unique case (mode_r)
        sbcpc_pkg::SBCPC_RESET: begin
          // Hold for the full duration after supply valid
          if (rst_cnt_r >= 32'(RST_CYC - 1)) begin
            mode_r <= sbcpc_pkg::SBCPC_NORMAL;
          end else begin
            rst_cnt_r <= rst_cnt_r + 32'h0000_0001;
          end
        end
        sbcpc_pkg::SBCPC_SLEEP: begin
          // Wake from sleep goes through reset
          if (wake_ev) begin
            mode_r    <= sbcpc_pkg::SBCPC_RESET;
            rst_cnt_r <= 32'h0000_0000;
          end
        end
        sbcpc_pkg::SBCPC_STOP: begin
          if (wake_ev) begin
            mode_r <= sbcpc_pkg::SBCPC_NORMAL;
          end
        end
        default: begin
          // Normal and Standby follow the software request
          if (wr_mcr) begin
            unique case (reg_wdata_i[sbcpc_pkg::MCR_MODE_LSB +: 2])
              2'h0: mode_r <= sbcpc_pkg::SBCPC_NORMAL;
              2'h1: mode_r <= sbcpc_pkg::SBCPC_STBY;
              2'h2: mode_r <= sbcpc_pkg::SBCPC_STOP;
              2'h3: mode_r <= sbcpc_pkg::SBCPC_SLEEP;
            endcase
          end
        end
      endcase
    end
  end

  // Stored mode request, read back by software
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mode_req_r <= 2'h0;
    end else if (wr_mcr) begin
      mode_req_r <= reg_wdata_i[sbcpc_pkg::MCR_MODE_LSB +: 2];
    end
  end

  // Battery fail: sticky in every mode, set beats clear
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      battery_fail_flag_r <= 1'b0;
    end else if (s_sfail) begin
      battery_fail_flag_r <= 1'b1;
    end else if (wr_mcr && reg_wdata_i[sbcpc_pkg::MCR_BATTERY_FAIL_FLAG]) begin
      battery_fail_flag_r <= 1'b0;
    end
  end

  // Temperature warning follows comparator; shutdown with hysteresis
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      temp_warn_r <= 1'b0;
      shut_r      <= 1'b0;
    end else begin
      temp_warn_r <= s_twarn;
      if (s_tshut) begin
        shut_r <= 1'b1;
      end else if (s_tcool) begin
        shut_r <= 1'b0;
      end
    end
  end

  // Watchdog fault held until a mode control write in Normal mode
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wd_fault_r <= 1'b0;
    end else if (s_wd_to || s_wd_early) begin
      wd_fault_r <= 1'b1;
    end else if (mode_r == sbcpc_pkg::SBCPC_NORMAL && wr_mcr) begin
      wd_fault_r <= 1'b0;
    end
  end

  // Enables for interrupts and wake-up inputs
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      int_en_r  <= sbcpc_pkg::INT_EN_RST;
      wake_en_r <= sbcpc_pkg::WAKE_EN_RST;
    end else begin
      if (wr_hit(reg_addr_i, sbcpc_pkg::ADDR_INT_EN, reg_wr_i)) begin
        int_en_r <= reg_wdata_i;
      end
      if (wr_hit(reg_addr_i, sbcpc_pkg::ADDR_WAKE_EN, reg_wr_i)) begin
        wake_en_r <= reg_wdata_i[3:0];
      end
    end
  end

  // Sticky status, write one to clear; a new event wins
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      int_stat_r <= 8'h00;
    end else if (wr_ist) begin
      int_stat_r <= (int_stat_r & ~reg_wdata_i) | int_set;
    end else begin
      int_stat_r <= int_stat_r | int_set;
    end
  end

  // Stop-mode wake pulse timer
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pulse_cnt_r <= 32'h0000_0000;
    end else if (wake_ev && mode_r == sbcpc_pkg::SBCPC_STOP) begin
      pulse_cnt_r <= 32'(WAKE_CYC);
    end else if (pulse_cnt_r != 32'h0000_0000) begin
      pulse_cnt_r <= pulse_cnt_r - 32'h0000_0001;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (reg_addr_i)
      sbcpc_pkg::ADDR_MODE_CTRL: begin
        rdata_nxt[sbcpc_pkg::MCR_MODE_LSB +: 2] = mode_req_r;
        rdata_nxt[sbcpc_pkg::MCR_BATTERY_FAIL_FLAG]  = battery_fail_flag_r;
        rdata_nxt[sbcpc_pkg::MCR_TEMPWARN] = temp_warn_r;
        rdata_nxt[sbcpc_pkg::MCR_TSHUT]    = shut_r;
        rdata_nxt[sbcpc_pkg::MCR_RESET]    =
          (mode_r == sbcpc_pkg::SBCPC_RESET);
      end
      sbcpc_pkg::ADDR_INT_EN:   rdata_nxt = int_en_r;
      sbcpc_pkg::ADDR_INT_STAT: rdata_nxt = int_stat_r;
      sbcpc_pkg::ADDR_WAKE_EN:  rdata_nxt = {4'h0, wake_en_r};
      sbcpc_pkg::ADDR_IO_STATUS: begin
        rdata_nxt[sbcpc_pkg::IOR_LEVEL_LSB +: 4] = s_level;
        rdata_nxt[sbcpc_pkg::IOR_SUP_UV]   = s_searly;
        rdata_nxt[sbcpc_pkg::IOR_WD_FAULT] = wd_fault_r;
      end
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Registered read data, valid the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // Pin outputs, all from flops; pass-through costs three cycles
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      bus_drive_dom_o    <= 1'b0;
      rxd_o              <= 1'b1;
      rst_n_o            <= 1'b0;
      int_n_o            <= 1'b1;
      watchdog_fault_n_o <= 1'b1;
      regulator_on_o     <= 1'b0;
      spi_sel_o          <= 1'b0;
    end else begin
      bus_drive_dom_o <= ~s_txd;
      rxd_o           <= ~s_bus;
      rst_n_o         <= (mode_r != sbcpc_pkg::SBCPC_RESET)
                         && !s_vdd_uv;
      int_n_o         <= !(|(int_stat_r & int_en_r))
                         && (pulse_cnt_r == 32'h0000_0000);
      watchdog_fault_n_o <= ~wd_fault_r;
      regulator_on_o  <= ~shut_r &&
                         (mode_r != sbcpc_pkg::SBCPC_SLEEP);
      spi_sel_o       <= ~s_cs_n;
    end
  end

endmodule : sbcpc_top

// file: dv/sbcpc_checker.sv
// Checker of pin timing of the pin control block
`timescale 1ns/1ps
module sbcpc_checker (
  input wire logic                  clk_i,
  input wire logic                  reset_n_i,
  input wire logic                  txd_i,
  input wire logic                  bus_dom_i,
  input wire logic                  spi_cs_n_i,
  input wire logic                  wd_timeout_i,
  input wire sbcpc_pkg::sbcpc_ana_t ana_i,
  input wire logic                  bus_drive_dom_o,
  input wire logic                  rxd_o,
  input wire logic                  rst_n_o,
  input wire logic                  watchdog_fault_n_o,
  input wire logic                  regulator_on_o,
  input wire logic                  spi_sel_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // Two sync flops and an output flop: four stable samples reach the pin
  property p_tx_dom;
    (!txd_i)[*4] |=> bus_drive_dom_o;
  endproperty
  a_tx_dom: assert property (p_tx_dom) else $error("bus not dominant");
  property p_tx_rec;
    txd_i[*4] |=> !bus_drive_dom_o;
  endproperty
  a_tx_rec: assert property (p_tx_rec) else $error("bus not recessive");
  property p_rx_dom;
    bus_dom_i[*4] |=> !rxd_o;
  endproperty
  a_rx_dom: assert property (p_rx_dom) else $error("rxd not low");
  property p_rx_rec;
    (!bus_dom_i)[*4] |=> rxd_o;
  endproperty
  a_rx_rec: assert property (p_rx_rec) else $error("rxd not high");
  property p_uv;
    ana_i.vdd_uv[*4] |=> !rst_n_o;
  endproperty
  a_uv: assert property (p_uv) else $error("reset not forced");
  // Watchdog fault must flag and reset together
  property p_wd;
    wd_timeout_i[*4] |=> !rst_n_o && !watchdog_fault_n_o;
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog fault lost");
  property p_sel;
    (!spi_cs_n_i)[*4] |=> spi_sel_o;
  endproperty
  a_sel: assert property (p_sel) else $error("port not selected");
  property p_shut;
    ana_i.temp_shut[*4] |=> !regulator_on_o;
  endproperty
  a_shut: assert property (p_shut) else $error("regulator still on");
endmodule : sbcpc_checker

bind sbcpc_top sbcpc_checker u_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .txd_i(txd_i),
  .bus_dom_i(bus_dom_i), .spi_cs_n_i(spi_cs_n_i),
  .wd_timeout_i(wd_timeout_i), .ana_i(ana_i),
  .bus_drive_dom_o(bus_drive_dom_o), .rxd_o(rxd_o), .rst_n_o(rst_n_o),
  .watchdog_fault_n_o(watchdog_fault_n_o),
  .regulator_on_o(regulator_on_o), .spi_sel_o(spi_sel_o)
);

// file: dv/sbcpc_bus_model.sv
// Bus model: other nodes and the wired bus level seen by the receiver
`timescale 1ns/1ps
module sbcpc_bus_model (
  input  wire logic drive_dom_i,
  input  wire logic other_dom_i,
  output logic      bus_dom_o
);
  // Dominant wins over recessive; line delay is under two cycles
  assign #6 bus_dom_o = drive_dom_i | other_dom_i;
endmodule : sbcpc_bus_model

// file: dv/sbcpc_top_test.sv
// Self-checking bench of the pin control block
`timescale 1ns/1ps
module sbcpc_top_test;
  localparam int WC = 8;
  logic                  clk_i, reset_n_i, txd, cs_n, wdt, wr, rd, oth;
  logic [3:0]            lvl, addr;
  logic [7:0]            wdat, rdat, v;
  sbcpc_pkg::sbcpc_ana_t ana;
  logic                  drv, bdom, rxd, rstn, intn, wdfn, regon, sel;
  logic                  sclk, mosi, miso, wet;
  real                   t_sck;
  int                    n_mismatch, comparisons, k;

  // Small counts keep the run short
  sbcpc_top #(.RST_CYC(20), .WAKE_CYC(WC)) u_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .txd_i(txd),
    .bus_dom_i(bdom), .level_inputs_i(lvl), .spi_cs_n_i(cs_n),
    .wd_timeout_i(wdt), .wd_early_trig_i(wet), .ana_i(ana),
    .spi_sclk_i(sclk), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdat), .bus_drive_dom_o(drv),
    .rxd_o(rxd), .rst_n_o(rstn), .int_n_o(intn),
    .watchdog_fault_n_o(wdfn), .regulator_on_o(regon), .spi_sel_o(sel)
  );
  sbcpc_bus_model u_bus (
    .drive_dom_i(drv), .other_dom_i(oth), .bus_dom_o(bdom)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  task automatic edge1;
    @(posedge clk_i);
  endtask : edge1

  // Two sync stages, the output flop and bus delay fit well inside twelve cycles
  task automatic settle;
    repeat (12) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdat <= d;
    wr   <= 1'b1;
    @(posedge clk_i);
    wr   <= 1'b0;
  endtask : wreg

  // Read data stand only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd   <= 1'b0;
    #1 v = rdat;
  endtask : rreg

  // Half a serial period of 125 ns, ending on a clock edge
  task automatic half_sck;
    t_sck = t_sck + 62.5;
    while ($realtime < t_sck) @(posedge clk_i);
  endtask : half_sck

  // Serial master: data out on rising, miso taken on falling
  task automatic spi_xfer(input logic sel, input logic [7:0] tx,
                          output logic [7:0] rx);
    @(posedge clk_i);
    cs_n <= !sel;
    t_sck = $realtime;
    half_sck();
    for (int i = 7; i >= 0; i--) begin
      half_sck();
      sclk <= 1'b1;
      mosi <= tx[i];
      half_sck();
      sclk <= 1'b0;
      rx[i] = miso;
    end
    half_sck();
    cs_n <= 1'b1;
  endtask : spi_xfer

  task automatic wait_rst;
    k = 0;
    while (rstn !== 1'b1 && k < 60) begin
      @(posedge clk_i);
      #1 k++;
    end
  endtask : wait_rst

  // Watchdog: the whole sequence needs about 1500 cycles
  initial begin
    #20000;
    n_mismatch++;
    final_report();
  end

  initial begin
    reset_n_i = 1'b0;
    {txd, cs_n, wdt, wr, rd, oth} = 6'h30;
    {sclk, mosi, wet} = 3'h0;
    t_sck = 0.0;
    {lvl, addr, wdat} = 16'h0000;
    ana = 6'h04;
    n_mismatch = 0;
    comparisons = 0;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    #1 check(rstn, 1'b0);
    wait_rst();
    check(k >= 10 && k <= 14, 1'b1);
    // Transmit and receive paths, then a foreign dominant bit
    edge1();
    txd <= 1'b0;
    settle();
    check(drv, 1'b1);
    check(rxd, 1'b0);
    edge1();
    txd <= 1'b1;
    oth <= 1'b1;
    settle();
    check(drv, 1'b0);
    check(rxd, 1'b0);
    edge1();
    oth  <= 1'b0;
    cs_n <= 1'b0;
    lvl  <= 4'hA;
    settle();
    check(rxd, 1'b1);
    check(sel, 1'b1);
    edge1();
    cs_n <= 1'b1;
    settle();
    check(sel, 1'b0);
    // Serial frames echo the previous whole byte
    spi_xfer(1'b1, 8'hA5, v);
    check(v, 8'h00);
    spi_xfer(1'b1, 8'h3C, v);
    check(v, 8'hA5);
    spi_xfer(1'b0, 8'hFF, v);
    spi_xfer(1'b1, 8'h00, v);
    check(v, 8'h3C);
    rreg(4'h2);
    check(v[3:0], 4'hA);
    rreg(4'hF);
    check(v, 8'h00);
    // Temperature warning: masked, enabled, held until cleared
    edge1();
    ana.temp_warn <= 1'b1;
    settle();
    check(intn, 1'b1);
    rreg(4'h0);
    check(v[5], 1'b1);
    rreg(4'h3);
    check(v[0], 1'b1);
    wreg(4'h1, 8'h01);
    edge1();
    ana.temp_warn <= 1'b0;
    settle();
    check(intn, 1'b0);
    wreg(4'h3, 8'h01);
    settle();
    check(intn, 1'b1);
    wreg(4'h1, 8'h00);
    // Battery fail latches after the supply returns
    edge1();
    ana.sup_fail <= 1'b1;
    settle();
    edge1();
    ana.sup_fail <= 1'b0;
    rreg(4'h0);
    check(v[4], 1'b1);
    wreg(4'h0, 8'h10);
    rreg(4'h0);
    check(v[4], 1'b0);
    edge1();
    ana.sup_early <= 1'b1;
    settle();
    rreg(4'h2);
    check(v[4], 1'b1);
    rreg(4'h3);
    check(v[1], 1'b1);
    edge1();
    ana.sup_early <= 1'b0;
    settle();
    wreg(4'h3, 8'h02);
    // Stop mode: early warning off, level change gives one pulse
    wreg(4'h4, 8'h0F);
    wreg(4'h0, 8'h02);
    edge1();
    ana.sup_early <= 1'b1;
    settle();
    rreg(4'h3);
    check(v[1], 1'b0);
    edge1();
    ana.sup_early <= 1'b0;
    lvl <= 4'h5;
    k = 0;
    while (intn !== 1'b0 && k < 40) begin
      @(posedge clk_i);
      #1 k++;
    end
    k = 0;
    while (intn === 1'b0 && k < 40) begin
      @(posedge clk_i);
      #1 k++;
    end
    check(8'(k), 8'(WC));
    edge1();
    ana <= 6'h08;
    settle();
    check(regon, 1'b0);
    edge1();
    ana <= 6'h24;
    settle();
    check(regon, 1'b1);
    check(rstn, 1'b0);
    edge1();
    ana <= 6'h04;
    wait_rst();
    check(rstn, 1'b1);
    // Trigger in the closed window resets and flags the fault
    edge1();
    wet <= 1'b1;
    settle();
    check(rstn, 1'b0);
    check(wdfn, 1'b0);
    edge1();
    wet <= 1'b0;
    wait_rst();
    check(rstn, 1'b1);
    wreg(4'h0, 8'h00);
    settle();
    check(wdfn, 1'b1);
    edge1();
    wdt <= 1'b1;
    settle();
    check(wdfn, 1'b0);
    check(rstn, 1'b0);
    final_report();
  end
endmodule : sbcpc_top_test
